// ==== dv/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst, wstrobe, rstrobe, generic_mode, irq;
    logic        tx_hw_taken, tx_busy, rx_frame_start, tx_start;
    logic        tx_bad_crc, rx_store_en, frame_done;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, v, sp;
    logic [2:0]  last_bytes, lb;
    int          err_total, n_tests, fd, ts, bc, cyc;
    txfifo_if link_if ();
    tx_fifo_port #(.depth_hw(4095)) tx_fifo_port_inst (.mclk(mclk),
        .rst(rst), .bus(link_if), .tx_hw_taken(tx_hw_taken),
        .tx_busy(tx_busy), .rx_frame_start(rx_frame_start),
        .tx_start(tx_start), .tx_bad_crc(tx_bad_crc),
        .rx_store_en(rx_store_en), .frame_done(frame_done),
        .last_bytes(last_bytes));
    tx_fifo_host tx_fifo_host_inst (.mclk(mclk), .rst(rst), .addr(addr),
        .wdata(wdata), .wstrobe(wstrobe), .rstrobe(rstrobe),
        .generic_mode(generic_mode), .rdata(rdata), .irq(irq),
        .link(link_if));
    txfifo_monitor txfifo_monitor_inst (.mclk(mclk), .rst(rst),
        .wr(link_if.wr), .rd(link_if.rd), .idx(link_if.idx),
        .wdata(link_if.wdata), .rdata(link_if.rdata),
        .generic_sel(link_if.generic_sel), .frame_done(frame_done),
        .last_bytes(last_bytes), .tx_start(tx_start),
        .tx_bad_crc(tx_bad_crc), .rx_store_en(rx_store_en));
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Pulses are counted here, not polled by tasks
    always @(posedge mclk)
    begin
        if (frame_done === 1'b1)
        begin
            fd++;
            lb = last_bytes;
        end
        if (tx_start === 1'b1) ts++;
        if (tx_bad_crc === 1'b1) bc++;
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            summarize();
        end
    end
    task summarize();
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %0t: got %h want %h", $time, s, e);
        end
    endtask
    task sw_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wstrobe <= 1'b1;
        @(posedge mclk);
        wstrobe <= 1'b0;
    endtask
    task sw_rd(input logic [3:0] a, output logic [31:0] o);
        @(posedge mclk);
        addr <= a;
        rstrobe <= 1'b1;
        @(posedge mclk);
        rstrobe <= 1'b0;
        #1 o = rdata;
    endtask
    // Device access through the host command registers
    task dev_wr(input logic [7:0] i, input logic [31:0] d);
        sw_wr(txfifo_pkg::ctl_idx_addr, {24'h0, i});
        sw_wr(txfifo_pkg::ctl_arg_addr, d);
        sw_wr(txfifo_pkg::ctl_cmd_addr, {30'h0, txfifo_pkg::cmd_write});
        repeat (3) @(posedge mclk);
    endtask
    task dev_rd(input logic [7:0] i, output logic [31:0] o);
        sw_wr(txfifo_pkg::ctl_idx_addr, {24'h0, i});
        sw_wr(txfifo_pkg::ctl_cmd_addr, {30'h0, txfifo_pkg::cmd_read});
        repeat (4) @(posedge mclk);
        sw_rd(txfifo_pkg::ctl_rdata_addr, o);
    endtask
    initial
    begin
        {wstrobe, rstrobe, tx_hw_taken, tx_busy, rx_frame_start} = 5'h00;
        {addr, wdata, generic_mode, rst} = {36'h0, 2'h3};
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        dev_rd(txfifo_pkg::free_space_idx, v);
        chk(v, txfifo_pkg::free_space_rst);
        dev_rd(txfifo_pkg::cut_through_idx, v);
        chk(v, txfifo_pkg::cut_through_rst);
        dev_wr(txfifo_pkg::cut_through_idx, 32'h1);
        sp = 32'h0fff;
        // Lengths 5..8 give one to four bytes in the last word
        for (int n = 5; n <= 8; n++)
        begin
            dev_wr(txfifo_pkg::frame_length_idx, n);
            dev_wr(txfifo_pkg::transmit_data_idx, 32'h04030201);
            chk(fd, n - 5);
            dev_wr(txfifo_pkg::transmit_data_idx, 32'h08070605);
            dev_wr(txfifo_pkg::transmit_data_idx, 32'hffffffff);
            sp = sp - txfifo_pkg::frame_overhead_hw - 2 - (n - 3) / 2;
            chk(lb, n - 4);
            chk(fd, n - 4);
            dev_rd(txfifo_pkg::free_space_idx, v);
            chk(v, sp);
        end
        chk(ts, 4);
        @(posedge mclk);
        tx_hw_taken <= 1'b1;
        repeat (3) @(posedge mclk);
        tx_hw_taken <= 1'b0;
        dev_rd(txfifo_pkg::free_space_idx, v);
        chk(v, sp + 3);
        sp = sp + 3;
        // Other protocol: length and data dropped, space reads zero
        @(posedge mclk);
        generic_mode <= 1'b0;
        dev_wr(txfifo_pkg::frame_length_idx, 32'h8);
        dev_wr(txfifo_pkg::transmit_data_idx, 32'h0);
        dev_rd(txfifo_pkg::free_space_idx, v);
        chk(v, 32'h0);
        @(posedge mclk);
        generic_mode <= 1'b1;
        dev_rd(txfifo_pkg::free_space_idx, v);
        chk(v, sp);
        dev_wr(txfifo_pkg::cut_through_idx, 32'h43);
        dev_wr(txfifo_pkg::frame_length_idx, 32'h14);
        dev_wr(txfifo_pkg::transmit_data_idx, 32'h1);
        chk(ts, 4);
        dev_wr(txfifo_pkg::transmit_data_idx, 32'h2);
        chk(ts, 5);
        tx_busy <= 1'b1;
        dev_wr(txfifo_pkg::flush_idx, 32'h2);
        tx_busy <= 1'b0;
        chk(bc, 1);
        dev_wr(txfifo_pkg::transmit_data_idx, 32'h3);
        dev_rd(txfifo_pkg::free_space_idx, v);
        chk(v, 32'h0fff);
        // Frame shorter than the threshold still starts
        dev_wr(txfifo_pkg::frame_length_idx, 32'h2);
        dev_wr(txfifo_pkg::transmit_data_idx, 32'h0);
        chk(ts, 6);
        dev_wr(txfifo_pkg::flush_idx, 32'h1);
        chk(rx_store_en, 0);
        rx_frame_start <= 1'b1;
        @(posedge mclk);
        rx_frame_start <= 1'b0;
        @(posedge mclk);
        #1 chk(rx_store_en, 1);
        // Read-done bit is set but masked
        sw_wr(txfifo_pkg::ctl_irq_en_addr, 32'h2);
        @(posedge mclk);
        #1 chk(irq, 0);
        dev_wr(txfifo_pkg::cut_through_idx, 32'h0);
        chk(irq, 1);
        sw_rd(txfifo_pkg::ctl_irq_stat_addr, v);
        chk(v[1:0], 2'h3);
        sw_wr(txfifo_pkg::ctl_irq_clr_addr, 32'h3);
        repeat (2) @(posedge mclk);
        #1 chk(irq, 0);
        dev_rd(txfifo_pkg::cut_through_idx, v);
        chk(v, 32'h43);
        summarize();
    end
endmodule

// ==== dv/txfifo_monitor.sv ====
module txfifo_monitor
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  idx,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic        generic_sel,
    input wire logic        frame_done,
    input wire logic [2:0]  last_bytes,
    input wire logic        tx_start,
    input wire logic        tx_bad_crc,
    input wire logic        rx_store_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Frame end only follows an accepted data write
    property p_done;
        frame_done |-> $past(wr && idx == txfifo_pkg::transmit_data_idx);
    endproperty
    a_done: assert property (p_done)
        else $error("frame end without data write");
    property p_last;
        frame_done |-> last_bytes != 3'h0 && last_bytes <= 3'h4;
    endproperty
    a_last: assert property (p_last)
        else $error("last word byte count out of range");
    // A frame end pulse lasts one cycle, never two cycles in a row
    property p_once;
        frame_done |=> !frame_done;
    endproperty
    a_once: assert property (p_once)
        else $error("two frame ends in a row");
    property p_sel;
        rd && idx == txfifo_pkg::free_space_idx && !generic_sel
            |=> rdata == 32'h0;
    endproperty
    a_sel: assert property (p_sel)
        else $error("space seen outside generic protocol");
    // Read data must hold until the next read
    property p_stand;
        !rd |=> $stable(rdata);
    endproperty
    a_stand: assert property (p_stand)
        else $error("read data moved without a read");
    property p_thr;
        wr && idx == txfifo_pkg::cut_through_idx
            |-> wdata[5:0] >= txfifo_pkg::threshold_min
            && wdata[5:0] <= txfifo_pkg::threshold_max;
    endproperty
    a_thr: assert property (p_thr)
        else $error("threshold out of range reached device");
    property p_rxfl;
        $fell(rx_store_en)
            |-> $past(wr && idx == txfifo_pkg::flush_idx && wdata[0]);
    endproperty
    a_rxfl: assert property (p_rxfl)
        else $error("receive storing stopped without flush");
    // Latency of one or two cycles tolerated
    property p_bad;
        tx_bad_crc
            |-> $past(wr && idx == txfifo_pkg::flush_idx && wdata[1])
            || $past(wr && idx == txfifo_pkg::flush_idx && wdata[1], 2);
    endproperty
    a_bad: assert property (p_bad)
        else $error("bad crc without transmit flush");
    property p_start;
        tx_start |-> $past(wr && idx == txfifo_pkg::transmit_data_idx);
    endproperty
    a_start: assert property (p_start)
        else $error("start without data write");
endmodule

// ==== shared/txfifo_if.sv ====
interface txfifo_if;
    logic        wr;
    logic        rd;
    logic [7:0]  idx;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        generic_sel;

    modport device
    (
        input  wr,
        input  rd,
        input  idx,
        input  wdata,
        input  generic_sel,
        output rdata
    );
    modport host
    (
        output wr,
        output rd,
        output idx,
        output wdata,
        output generic_sel,
        input  rdata
    );
endinterface

// ==== shared/txfifo_pkg.sv ====
package txfifo_pkg;
    // Register indices, byte address is four times the index
    localparam logic [7:0] frame_length_idx   = 8'h30;
    localparam logic [7:0] transmit_data_idx  = 8'h31;
    localparam logic [7:0] free_space_idx     = 8'h32;
    localparam logic [7:0] cut_through_idx    = 8'h34;
    localparam logic [7:0] flush_idx          = 8'h36;
    // Controller registers, local to the host end
    localparam logic [3:0] ctl_cmd_addr       = 4'h0;
    localparam logic [3:0] ctl_arg_addr       = 4'h1;
    localparam logic [3:0] ctl_status_addr    = 4'h2;
    localparam logic [3:0] ctl_rdata_addr     = 4'h3;
    localparam logic [3:0] ctl_irq_stat_addr  = 4'h4;
    localparam logic [3:0] ctl_irq_clr_addr   = 4'h5;
    localparam logic [3:0] ctl_irq_en_addr    = 4'h6;
    localparam logic [3:0] ctl_idx_addr       = 4'h7;
    // Field layouts
    localparam int frame_byte_count_w     = 11;
    localparam int free_space_w           = 14;
    localparam int threshold_w            = 6;
    localparam int transmit_fifo_flush_bit = 1;
    localparam int receive_fifo_flush_bit  = 0;
    // Reset values and threshold limits
    localparam logic [31:0] free_space_rst  = 32'h0000_0fff;
    localparam logic [31:0] cut_through_rst = 32'h0000_0041;
    localparam logic [5:0]  threshold_min   = 6'h01;
    localparam logic [5:0]  threshold_max   = 6'h1a;
    // Per-frame size and header slot, in half words of space
    localparam logic [13:0] frame_overhead_hw = 14'h0002;
    // Controller commands
    localparam logic [1:0] cmd_write = 2'h1;
    localparam logic [1:0] cmd_read  = 2'h2;
endpackage

// ==== src/tx_fifo_host.sv ====
// Host end: commands from software become register accesses
module tx_fifo_host
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wstrobe,
    input  wire logic        rstrobe,
    input  wire logic        generic_mode,
    output logic [31:0]      rdata,
    output logic             irq,
    txfifo_if.host           link
);
    logic [7:0]  idx_r;
    logic [31:0] arg_r;
    logic [31:0] got_r;
    logic        pend_r;
    logic [1:0]  stat_r;
    logic [1:0]  en_r;
    logic        bad_thr;

    // Threshold outside one to twenty-six is refused
    assign bad_thr = idx_r == txfifo_pkg::cut_through_idx
        && (wdata[1:0] == txfifo_pkg::cmd_write)
        && (arg_r[5:0] < txfifo_pkg::threshold_min
            || arg_r[5:0] > txfifo_pkg::threshold_max);

    // Issue one bus access per command
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            link.wr          <= 1'b0;
            link.rd          <= 1'b0;
            link.idx         <= 8'h00;
            link.wdata       <= 32'h0000_0000;
            link.generic_sel <= 1'b0;
            idx_r            <= 8'h00;
            arg_r            <= 32'h0000_0000;
        end
        else
        begin
            link.generic_sel <= generic_mode;
            link.wr <= wstrobe && addr == txfifo_pkg::ctl_cmd_addr
                       && wdata[1:0] == txfifo_pkg::cmd_write && !bad_thr;
            link.rd <= wstrobe && addr == txfifo_pkg::ctl_cmd_addr
                       && wdata[1:0] == txfifo_pkg::cmd_read;
            link.idx   <= idx_r;
            link.wdata <= arg_r;
            if (wstrobe && addr == txfifo_pkg::ctl_arg_addr)
                arg_r <= wdata;
            if (wstrobe && addr == txfifo_pkg::ctl_idx_addr)
                idx_r <= wdata[7:0];
        end
    end

    // Capture returned data; events: read done, threshold refused
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pend_r <= 1'b0;
            got_r  <= 32'h0000_0000;
            stat_r <= 2'h0;
            en_r   <= 2'h0;
        end
        else
        begin
            pend_r <= link.rd;
            if (pend_r)
                got_r <= link.rdata;
            // Set wins over clear
            stat_r <= (stat_r & ~((wstrobe
                       && addr == txfifo_pkg::ctl_irq_clr_addr)
                       ? wdata[1:0] : 2'h0))
                      | {wstrobe && addr == txfifo_pkg::ctl_cmd_addr
                         && bad_thr, pend_r};
            if (wstrobe && addr == txfifo_pkg::ctl_irq_en_addr)
                en_r <= wdata[1:0];
        end
    end

    // Software read port and interrupt
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rdata <= 32'h0000_0000;
            irq   <= 1'b0;
        end
        else
        begin
            irq <= |(stat_r & en_r);
            if (rstrobe)
                unique case (addr)
                    txfifo_pkg::ctl_rdata_addr:    rdata <= got_r;
                    txfifo_pkg::ctl_status_addr:
                        rdata <= {31'h00000000, pend_r};
                    txfifo_pkg::ctl_irq_stat_addr:
                        rdata <= {30'h00000000, stat_r};
                    txfifo_pkg::ctl_irq_en_addr:
                        rdata <= {30'h00000000, en_r};
                    txfifo_pkg::ctl_arg_addr:      rdata <= arg_r;
                    txfifo_pkg::ctl_idx_addr:
                        rdata <= {24'h000000, idx_r};
                    default:                       rdata <= 32'h0000_0000;
                endcase
        end
    end
endmodule

// ==== src/tx_fifo_port.sv ====
module tx_fifo_port
#(
    parameter int depth_hw = 4095
)
(
    input  wire logic mclk,
    input  wire logic rst,
    txfifo_if.device  bus,
    input  wire logic tx_hw_taken,
    input  wire logic tx_busy,
    input  wire logic rx_frame_start,
    output logic      tx_start,
    output logic      tx_bad_crc,
    output logic      rx_store_en,
    output logic      frame_done,
    output logic [2:0] last_bytes
);
    // Frame, occupancy and threshold state
    logic [10:0] frame_len_r;
    logic [10:0] sent_r;
    logic        armed_r;
    logic [13:0] used_r;
    logic [13:0] fill_hw_r;
    logic [5:0]  thresh_r;
    logic        cut_en_r;
    logic [31:0] rdata_r;
    logic [13:0] space;
    logic [10:0] remain;
    logic [2:0]  nbytes;
    logic [13:0] add_hw;
    logic        do_wr;
    logic        do_data;
    logic        do_len;
    logic        tx_flush;
    logic        rx_flush;
    logic [13:0] inc_hw;
    logic [13:0] dec_hw;
    logic        last_wr;
    logic        cross_thr;

    // One register hit decode shared by every write path
    function automatic logic wr_hit
    (
        input logic       strobe,
        input logic [7:0] sel,
        input logic [7:0] want
    );
        return strobe && sel == want;
    endfunction

    // Decode gated by protocol select
    assign do_wr    = bus.wr & bus.generic_sel;
    assign do_len   = wr_hit(do_wr, bus.idx, txfifo_pkg::frame_length_idx);
    assign do_data  = wr_hit(do_wr, bus.idx, txfifo_pkg::transmit_data_idx)
                      && armed_r;
    // Flushing works under either protocol
    assign tx_flush = wr_hit(bus.wr, bus.idx, txfifo_pkg::flush_idx)
                      && bus.wdata[txfifo_pkg::transmit_fifo_flush_bit];
    assign rx_flush = wr_hit(bus.wr, bus.idx, txfifo_pkg::flush_idx)
                      && bus.wdata[txfifo_pkg::receive_fifo_flush_bit];
    assign remain   = frame_len_r - sent_r;
    // Only valid bytes of the last word are stored
    assign nbytes   = (remain < 11'd4) ? remain[2:0] : 3'h4;
    assign add_hw   = {12'h000, nbytes[2:1]} + {13'h0000, nbytes[0]};
    assign space    = 14'(depth_hw) - used_r;
    assign last_wr  = do_data && remain <= 11'd4;

    // Charge and drain in one sum; a drain beside a write must not
    // be lost, or the space report drifts for good
    assign inc_hw   = do_len ? txfifo_pkg::frame_overhead_hw
                      : (do_data ? add_hw : 14'h0000);
    assign dec_hw   = {13'h0000, tx_hw_taken && used_r != 14'h0000};

    // Short frames below the threshold start at their last word,
    // else they would wait in the FIFO for good
    assign cross_thr = do_data && fill_hw_r < 14'(thresh_r)
                       && (fill_hw_r + add_hw >= 14'(thresh_r) || last_wr);

    // Frame length and byte counter
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            frame_len_r <= 11'h000;
            sent_r      <= 11'h000;
            armed_r     <= 1'b0;
            frame_done  <= 1'b0;
            last_bytes  <= 3'h0;
        end
        else
        begin
            frame_done <= 1'b0;
            if (do_len)
            begin
                frame_len_r <= bus.wdata[10:0];
                sent_r      <= 11'h000;
                armed_r     <= bus.wdata[10:0] != 11'h000;
            end
            else if (do_data)
            begin
                sent_r <= sent_r + 11'(nbytes);
                if (last_wr)
                begin
                    armed_r    <= 1'b0;
                    frame_done <= 1'b1;
                    last_bytes <= nbytes;
                end
            end
            // Leftover words of a flushed frame have nowhere to go
            else if (tx_flush)
                armed_r <= 1'b0;
        end
    end

    // FIFO occupancy in half words, overhead charged at frame start
    always_ff @(posedge mclk)
    begin
        if (rst || tx_flush)
        begin
            used_r    <= 14'h0000;
            fill_hw_r <= 14'h0000;
        end
        else
        begin
            used_r <= used_r + inc_hw - dec_hw;
            if (do_len)
                fill_hw_r <= 14'h0000;
            else if (do_data)
                fill_hw_r <= fill_hw_r + add_hw;
        end
    end

    // Threshold register and transmit start
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            thresh_r <= txfifo_pkg::cut_through_rst[5:0];
            cut_en_r <= txfifo_pkg::cut_through_rst[6];
            tx_start <= 1'b0;
        end
        else
        begin
            if (wr_hit(bus.wr, bus.idx, txfifo_pkg::cut_through_idx))
            begin
                thresh_r <= bus.wdata[5:0];
                cut_en_r <= bus.wdata[6];
            end
            // Store-forward waits for whole frame; cut-through starts
            // on crossing the threshold or at a short frame's end
            tx_start <= cut_en_r ? cross_thr : last_wr;
        end
    end

    // Flush effects on the two datapaths
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tx_bad_crc  <= 1'b0;
            rx_store_en <= 1'b1;
        end
        else
        begin
            tx_bad_crc <= tx_flush & tx_busy;
            // Flush wins over a frame start in the same cycle
            if (rx_flush)
                rx_store_en <= 1'b0;
            else if (rx_frame_start)
                rx_store_en <= 1'b1;
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (rst)
            rdata_r <= 32'h0000_0000;
        else if (bus.rd)
            unique case (bus.idx)
                txfifo_pkg::frame_length_idx:
                    rdata_r <= {21'h000000, frame_len_r};
                txfifo_pkg::free_space_idx:
                    rdata_r <= bus.generic_sel
                        ? {18'h00000, space} : 32'h0000_0000;
                txfifo_pkg::cut_through_idx:
                    rdata_r <= {25'h0000000, cut_en_r, thresh_r};
                default:
                    rdata_r <= 32'h0000_0000;
            endcase
    end
    // Registered so the answer stands until the next read
    assign bus.rdata = rdata_r;
endmodule
